/* logic/acfo_defs.svh */
`ifndef ACFO_DEFS_SVH
`define ACFO_DEFS_SVH

// Register byte addresses.
`define ACFO_X_HIGH_ADDR 8'h08
`define ACFO_X_MID_ADDR 8'h09
`define ACFO_X_LOW_ADDR 8'h0a
`define ACFO_Y_HIGH_ADDR 8'h0b
`define ACFO_Y_MID_ADDR 8'h0c
`define ACFO_Y_LOW_ADDR 8'h0d
`define ACFO_Z_HIGH_ADDR 8'h0e
`define ACFO_Z_MID_ADDR 8'h0f
`define ACFO_Z_LOW_ADDR 8'h10
`define ACFO_QUEUE_ADDR 8'h11
`define ACFO_XT_HIGH_ADDR 8'h1e
`define ACFO_XT_LOW_ADDR 8'h1f
`define ACFO_YT_HIGH_ADDR 8'h20
`define ACFO_YT_LOW_ADDR 8'h21
`define ACFO_ZT_HIGH_ADDR 8'h22
`define ACFO_ZT_LOW_ADDR 8'h23

// Field positions and reset values.
`define ACFO_TRIM_SHIFT 4
`define ACFO_RESULT_RST 20'h00000
`define ACFO_TRIM_RST 16'h0000
`define ACFO_BYTE_RST 8'h00
`define ACFO_WORD_BYTES 2'h3

`endif

/* logic/acfo_pkg.sv */
package acfo_pkg;

    typedef logic [19:0] acfo_result_t;
    typedef logic [15:0] acfo_trim_t;

    typedef struct packed {
        acfo_result_t x;
        acfo_result_t y;
        acfo_result_t z;
    } acfo_axes_s;

    typedef struct packed {
        logic start;
        logic next;
        logic [7:0] addr;
    } acfo_read_req_s;

    typedef struct packed {
        logic strobe;
        logic [7:0] addr;
        logic [7:0] data;
    } acfo_write_req_s;

endpackage

/* logic/acfo_regs.sv */
`timescale 1ns/100ps
`include "acfo_defs.svh"

module acfo_regs #(
    parameter int RES_W = 20,
    parameter int TRIM_W = 16
) (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Processed samples from the signal chain.
    input wire logic sample_valid_in,
    input wire acfo_pkg::acfo_axes_s sample_in,
    // Show-ahead sample queue read side.
    input wire logic [23:0] queue_word_in,
    output logic queue_pop_out,
    // Byte-level register access from the serial front end.
    input wire acfo_pkg::acfo_read_req_s rd_req_in,
    input wire acfo_pkg::acfo_write_req_s wr_req_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic [7:0] addr_ptr_out,
    // Trimmed results for the rest of the device.
    output acfo_pkg::acfo_axes_s result_out
);
    import acfo_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration checks.
    // ----------------------------------------------------------------
    // The byte map is fixed, so any other width would be read back wrong.
    if (RES_W != 20) begin : g_bad_res_w
        $error("acfo_regs supports only 20-bit results.");
    end
    if (TRIM_W != 16) begin : g_bad_trim_w
        $error("acfo_regs supports only 16-bit trims.");
    end

    // ----------------------------------------------------------------
    // Trim write decode.
    // ----------------------------------------------------------------
    // Each trim byte has its own enable, so the two halves of a trim can be
    // written independently and in either order.
    logic wr_xt_high;
    logic wr_xt_low;
    logic wr_yt_high;
    logic wr_yt_low;
    logic wr_zt_high;
    logic wr_zt_low;

    always_comb begin
        wr_xt_high = wr_req_in.strobe && wr_req_in.addr == `ACFO_XT_HIGH_ADDR;
        wr_xt_low = wr_req_in.strobe && wr_req_in.addr == `ACFO_XT_LOW_ADDR;
        wr_yt_high = wr_req_in.strobe && wr_req_in.addr == `ACFO_YT_HIGH_ADDR;
        wr_yt_low = wr_req_in.strobe && wr_req_in.addr == `ACFO_YT_LOW_ADDR;
        wr_zt_high = wr_req_in.strobe && wr_req_in.addr == `ACFO_ZT_HIGH_ADDR;
        wr_zt_low = wr_req_in.strobe && wr_req_in.addr == `ACFO_ZT_LOW_ADDR;
    end

    // ----------------------------------------------------------------
    // Offset trim registers.
    // ----------------------------------------------------------------
    // Writes to read-only addresses fall through the decode and are
    // dropped without any side effect.
    acfo_trim_t x_trim_ff;
    acfo_trim_t y_trim_ff;
    acfo_trim_t z_trim_ff;

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            x_trim_ff <= `ACFO_TRIM_RST;
        end else begin
            if (wr_xt_high) begin
                x_trim_ff[15:8] <= wr_req_in.data;
            end
            if (wr_xt_low) begin
                x_trim_ff[7:0] <= wr_req_in.data;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            y_trim_ff <= `ACFO_TRIM_RST;
        end else begin
            if (wr_yt_high) begin
                y_trim_ff[15:8] <= wr_req_in.data;
            end
            if (wr_yt_low) begin
                y_trim_ff[7:0] <= wr_req_in.data;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            z_trim_ff <= `ACFO_TRIM_RST;
        end else begin
            if (wr_zt_high) begin
                z_trim_ff[15:8] <= wr_req_in.data;
            end
            if (wr_zt_low) begin
                z_trim_ff[7:0] <= wr_req_in.data;
            end
        end
    end

    // ----------------------------------------------------------------
    // Trim addition and result registers.
    // ----------------------------------------------------------------
    // The trim is scaled by sixteen and the sum wraps in 20 bits.
    // There is no saturation: a large trim on a large result folds over,
    // which the user must avoid when choosing the trim.
    function automatic acfo_result_t add_trim(acfo_result_t raw, acfo_trim_t trim);
        acfo_result_t scaled;
        scaled = {trim, 4'h0};
        return raw + scaled;
    endfunction

    acfo_axes_s res_ff;

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            res_ff.x <= `ACFO_RESULT_RST;
            res_ff.y <= `ACFO_RESULT_RST;
            res_ff.z <= `ACFO_RESULT_RST;
        end else if (sample_valid_in) begin
            res_ff.x <= add_trim(sample_in.x, x_trim_ff);
            res_ff.y <= add_trim(sample_in.y, y_trim_ff);
            res_ff.z <= add_trim(sample_in.z, z_trim_ff);
        end
    end

    assign result_out = res_ff;

    // ----------------------------------------------------------------
    // Read address selection and pointer.
    // ----------------------------------------------------------------
    // A request names its own address on start; a next byte takes the
    // pointer left by the byte before it.
    logic [7:0] ptr_ff;
    logic direct_ff;
    logic [1:0] idx_ff;
    logic [23:0] word_ff;
    logic rd_any;
    logic [7:0] cur_addr;
    logic cur_direct;
    logic queue_hit;
    logic queue_skip;

    always_comb begin
        rd_any = rd_req_in.start | rd_req_in.next;
        cur_addr = rd_req_in.start ? rd_req_in.addr : ptr_ff;
        cur_direct = rd_req_in.start | direct_ff;
        queue_hit = rd_any && cur_addr == `ACFO_QUEUE_ADDR && cur_direct;
        queue_skip = rd_any && cur_addr == `ACFO_QUEUE_ADDR && !cur_direct;
    end

    // The pointer holds at the queue port during a direct burst and moves
    // one on for every other byte, the skipped queue port included.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ptr_ff <= `ACFO_BYTE_RST;
        end else if (rd_any) begin
            if (queue_hit) begin
                ptr_ff <= cur_addr;
            end else begin
                ptr_ff <= cur_addr + 8'h01;
            end
        end
    end

    // A read that starts at the queue port is direct; any other start or an
    // auto-increment arrival is not, and a burst keeps the flag it began with.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            direct_ff <= 1'b0;
        end else if (rd_any) begin
            direct_ff <= queue_hit;
        end
    end

    assign addr_ptr_out = ptr_ff;

    // ----------------------------------------------------------------
    // Queue word unpacking.
    // ----------------------------------------------------------------
    // The byte index survives between single reads so that two later
    // single reads finish a word begun by an earlier one.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            idx_ff <= 2'h0;
        end else if (queue_hit) begin
            if (idx_ff == `ACFO_WORD_BYTES - 2'h1) begin
                idx_ff <= 2'h0;
            end else begin
                idx_ff <= idx_ff + 2'h1;
            end
        end
    end

    // The head word is copied on the first byte, because the queue moves
    // on once the pop reaches it and the later bytes must not follow it.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            word_ff <= 24'h000000;
        end else if (queue_hit && idx_ff == 2'h0) begin
            word_ff <= queue_word_in;
        end
    end

    // The pop is registered, one cycle after the first byte of each word.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            queue_pop_out <= 1'b0;
        end else begin
            queue_pop_out <= queue_hit && idx_ff == 2'h0;
        end
    end

    // ----------------------------------------------------------------
    // Read data mux.
    // ----------------------------------------------------------------
    // The queue port comes first, so that a direct read never falls into
    // the plain map; the skipped queue port and unmapped addresses read zero.
    // Results are not held across a multi-byte read, so a sample that lands
    // between two bytes of one axis mixes old and new bytes.
    logic [7:0] nxt_rd_data;

    always_comb begin
        nxt_rd_data = `ACFO_BYTE_RST;
        if (queue_hit) begin
            case (idx_ff)
                2'h0: nxt_rd_data = queue_word_in[23:16];
                2'h1: nxt_rd_data = word_ff[15:8];
                default: nxt_rd_data = word_ff[7:0];
            endcase
        end else if (queue_skip) begin
            nxt_rd_data = `ACFO_BYTE_RST;
        end else begin
            case (cur_addr)
                `ACFO_X_HIGH_ADDR: nxt_rd_data = res_ff.x[19:12];
                `ACFO_X_MID_ADDR: nxt_rd_data = res_ff.x[11:4];
                `ACFO_X_LOW_ADDR: nxt_rd_data = {res_ff.x[3:0], 4'h0};
                `ACFO_Y_HIGH_ADDR: nxt_rd_data = res_ff.y[19:12];
                `ACFO_Y_MID_ADDR: nxt_rd_data = res_ff.y[11:4];
                `ACFO_Y_LOW_ADDR: nxt_rd_data = {res_ff.y[3:0], 4'h0};
                `ACFO_Z_HIGH_ADDR: nxt_rd_data = res_ff.z[19:12];
                `ACFO_Z_MID_ADDR: nxt_rd_data = res_ff.z[11:4];
                `ACFO_Z_LOW_ADDR: nxt_rd_data = {res_ff.z[3:0], 4'h0};
                `ACFO_XT_HIGH_ADDR: nxt_rd_data = x_trim_ff[15:8];
                `ACFO_XT_LOW_ADDR: nxt_rd_data = x_trim_ff[7:0];
                `ACFO_YT_HIGH_ADDR: nxt_rd_data = y_trim_ff[15:8];
                `ACFO_YT_LOW_ADDR: nxt_rd_data = y_trim_ff[7:0];
                `ACFO_ZT_HIGH_ADDR: nxt_rd_data = z_trim_ff[15:8];
                `ACFO_ZT_LOW_ADDR: nxt_rd_data = z_trim_ff[7:0];
                default: nxt_rd_data = `ACFO_BYTE_RST;
            endcase
        end
    end

    // The valid pulse follows every accepted byte request by one cycle.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_any;
        end
    end

    // The read byte stands until the next request replaces it.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_data_out <= `ACFO_BYTE_RST;
        end else if (rd_any) begin
            rd_data_out <= nxt_rd_data;
        end
    end

endmodule // acfo_regs

/* verification/acfo_regs_props.sv */
`timescale 1ns/100ps
// ------------------------------
// Readout checker.
// ------------------------------
module acfo_regs_props (
    // Watched ports.
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic sample_valid_in,
    input wire acfo_pkg::acfo_axes_s sample_in,
    input wire logic [23:0] queue_word_in,
    input wire logic queue_pop_out,
    input wire acfo_pkg::acfo_read_req_s rd_req_in,
    input wire acfo_pkg::acfo_write_req_s wr_req_in,
    input wire logic [7:0] rd_data_out,
    input wire logic rd_valid_out,
    input wire logic [7:0] addr_ptr_out,
    input wire acfo_pkg::acfo_axes_s result_out
);
    import acfo_pkg::*;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    // Remembers that the last byte read came from 0x10.
    logic from_low_ff;
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            from_low_ff <= 1'b0;
        end else if (rd_req_in.start || rd_req_in.next) begin
            from_low_ff <= rd_req_in.start ? rd_req_in.addr == 8'h10 : addr_ptr_out == 8'h10;
        end
    end
    sequence s_req;
        rd_req_in.start || rd_req_in.next;
    endsequence
    sequence s_auto;
        rd_req_in.next && addr_ptr_out == 8'h11 && from_low_ff;
    endsequence
    property p_answer;
        s_req |=> rd_valid_out;
    endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
    property p_quiet;
        !(rd_req_in.start || rd_req_in.next) |=> !rd_valid_out && !queue_pop_out;
    endproperty
    a_quiet: assert property (p_quiet) else $error("answer or pop without read");
    property p_auto;
        s_auto |=> rd_data_out == 8'h00 && addr_ptr_out == 8'h12 && !queue_pop_out;
    endproperty
    a_auto: assert property (p_auto) else $error("bad auto-increment arrival");
    property p_burst_ptr;
        rd_req_in.next && addr_ptr_out == 8'h11 && !from_low_ff |=> addr_ptr_out == 8'h11;
    endproperty
    a_burst_ptr: assert property (p_burst_ptr) else $error("queue burst moved pointer");
    property p_pop_gap;
        queue_pop_out |=> !queue_pop_out [*2];
    endproperty
    a_pop_gap: assert property (p_pop_gap) else $error("pops closer than a word");
    property p_pop_word;
        queue_pop_out |-> rd_data_out == $past(queue_word_in[23:16]);
    endproperty
    a_pop_word: assert property (p_pop_word) else $error("pop without top byte");
    property p_low_nib;
        rd_req_in.start && rd_req_in.addr inside {8'h0a, 8'h0d, 8'h10} |=> rd_data_out[3:0] == 4'h0;
    endproperty
    a_low_nib: assert property (p_low_nib) else $error("reserved nibble set");
    property p_x_high;
        rd_req_in.start && rd_req_in.addr == 8'h08 |=> rd_data_out == $past(result_out.x[19:12]);
    endproperty
    a_x_high: assert property (p_x_high) else $error("x high byte wrong");
endmodule // acfo_regs_props

bind acfo_regs acfo_regs_props u_props (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .sample_valid_in(sample_valid_in), .sample_in(sample_in), .queue_word_in(queue_word_in),
    .queue_pop_out(queue_pop_out), .rd_req_in(rd_req_in), .wr_req_in(wr_req_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .addr_ptr_out(addr_ptr_out),
    .result_out(result_out));

/* verification/acfo_host_model.sv */
`timescale 1ns/100ps
// ------------------------------
// Host issuing byte reads and writes.
// ------------------------------
module acfo_host_model (
    // Clock and answer.
    input wire logic mclk_in,
    input wire logic [7:0] rd_data_in,
    // Requests.
    output acfo_pkg::acfo_read_req_s rd_req_out,
    output acfo_pkg::acfo_write_req_s wr_req_out
);
    import acfo_pkg::*;
    initial begin
        rd_req_out = '0;
        wr_req_out = '0;
    end
    task automatic rd(input logic nx, input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        #1;
        rd_req_out = '{start: !nx, next: nx, addr: a};
        @(posedge mclk_in);
        #1;
        d = rd_data_in;
        rd_req_out = '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_in);
        #1;
        wr_req_out = '{strobe: 1'b1, addr: a, data: v};
        @(posedge mclk_in);
        #1;
        wr_req_out = '0;
    endtask
endmodule // acfo_host_model

/* verification/acfo_regs_test.sv */
`timescale 1ns/100ps
// ------------------------------
// Register block bench.
// ------------------------------
module acfo_regs_test;
    import acfo_pkg::*;
    logic mclk_in, sys_rst_in, sample_valid_in, queue_pop_out, rd_valid_out;
    acfo_axes_s sample_in, result_out;
    acfo_read_req_s rd_req;
    acfo_write_req_s wr_req;
    logic [7:0] rd_data_out, addr_ptr_out, d;
    logic [1:0] qi;
    logic [23:0] words [4] = '{24'ha1b2c3, 24'hd4e5f6, 24'h102030, 24'h7f8091};
    int fails = 0;
    int n_compared = 0;
    acfo_regs uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .sample_valid_in(sample_valid_in),
        .sample_in(sample_in), .queue_word_in(words[qi]), .queue_pop_out(queue_pop_out),
        .rd_req_in(rd_req), .wr_req_in(wr_req), .rd_data_out(rd_data_out),
        .rd_valid_out(rd_valid_out), .addr_ptr_out(addr_ptr_out), .result_out(result_out));
    acfo_host_model host (.mclk_in(mclk_in), .rd_data_in(rd_data_out), .rd_req_out(rd_req),
        .wr_req_out(wr_req));
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            qi <= 2'h0;
        end else if (queue_pop_out) begin
            qi <= qi + 2'h1;
        end
    end
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic t_reset_values;
        for (int a = 8; a <= 8'h23; a++) begin
            if (a <= 8'h10 || a >= 8'h1e) begin
                host.rd(1'b0, 8'(a), d);
                chk("reset byte", 0, d);
            end
        end
    endtask
    task automatic t_trims;
        for (int k = 0; k < 6; k++) host.wr(8'h1e + 8'(k), 8'(8'h11 * (k + 1)));
        host.wr(8'h08, 8'hff);
        for (int k = 0; k < 6; k++) begin
            host.rd(1'b0, 8'h1e + 8'(k), d);
            chk("trim", 8'(8'h11 * (k + 1)), d);
        end
        host.rd(1'b0, 8'h08, d);
        chk("read-only", 0, d);
    endtask
    task automatic t_sample;
        logic [19:0] raw [3] = '{20'h12345, 20'hfff00, 20'h80010};
        logic [19:0] e;
        @(posedge mclk_in);
        #1;
        sample_in = {raw[0], raw[1], raw[2]};
        sample_valid_in = 1'b1;
        @(posedge mclk_in);
        #1;
        sample_valid_in = 1'b0;
        for (int k = 0; k < 3; k++) begin
            e = raw[k] + {8'(8'h11 * (2 * k + 1)), 8'(8'h11 * (2 * k + 2)), 4'h0};
            chk("trimmed result", e, k == 0 ? result_out.x : (k == 1 ? result_out.y : result_out.z));
            host.rd(1'b0, 8'h08 + 8'(3 * k), d);
            chk("high byte", e[19:12], d);
            host.rd(1'b1, 8'h00, d);
            chk("mid byte", e[11:4], d);
            host.rd(1'b1, 8'h00, d);
            chk("low nibble", {e[3:0], 4'h0}, d);
        end
    endtask
    task automatic t_fifo;
        for (int k = 0; k < 9; k++) begin
            host.rd(k > 0 && k < 6, 8'h11, d);
            chk("queue byte", words[k / 3][23 - 8 * (k % 3) -: 8], d);
            chk("pointer", 8'h11, addr_ptr_out);
        end
    endtask
    task automatic t_auto;
        host.rd(1'b0, 8'h10, d);
        host.rd(1'b1, 8'h00, d);
        chk("auto byte", 0, d);
        chk("auto pointer", 8'h12, addr_ptr_out);
        chk("pops", 3, qi);
    endtask
    task automatic t_mid_reset;
        host.wr(8'h1e, 8'h5a);
        @(posedge mclk_in);
        #1;
        sys_rst_in = 1'b1;
        @(posedge mclk_in);
        #1;
        sys_rst_in = 1'b0;
        chk("result after reset", 0, result_out.x);
        host.rd(1'b0, 8'h1e, d);
        chk("trim after reset", 0, d);
        host.rd(1'b0, 8'h11, d);
        chk("queue after reset", words[0][23:16], d);
    endtask
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    initial begin
        #100000;
        fails++;
        complete_run;
    end
    initial begin
        sys_rst_in = 1'b1;
        sample_valid_in = 1'b0;
        sample_in = '0;
        repeat (3) @(posedge mclk_in);
        #1;
        sys_rst_in = 1'b0;
        t_reset_values;
        t_trims;
        t_sample;
        t_fifo;
        t_auto;
        t_mid_reset;
        complete_run;
    end
endmodule // acfo_regs_test
